// >>> cpp_cfg.svh
// constants for the control packet policer: offsets, fields, reset values, timing
`ifndef CPP_CFG_SVH
`define CPP_CFG_SVH
// ==========================================================
// register offsets (word index on the plain register port)
`define CPP_ADDR_W 4
`define CPP_OFS_SEL 4'h0
`define CPP_OFS_MODE 4'h1
`define CPP_OFS_PPI 4'h2
`define CPP_OFS_WITHIN 4'h3
`define CPP_OFS_INIT 4'h4
`define CPP_OFS_KBPS 4'h5
`define CPP_OFS_MBS 4'h6
`define CPP_OFS_DETECT 4'h7
`define CPP_OFS_ACTION 4'h8
`define CPP_OFS_HOLD 4'h9
`define CPP_OFS_STATUS 4'ha
`define CPP_OFS_POOL 4'hb
`define CPP_OFS_POOLST 4'hc
`define CPP_OFS_CMD 4'hd
// ==========================================================
// field positions
`define CPP_MODE_KBPS_BIT 0
`define CPP_MODE_MBS_KB_BIT 1
`define CPP_MODE_MBS_SET_BIT 2
`define CPP_MODE_LOCMON_BIT 3
`define CPP_MODE_LOG_EN_BIT 4
`define CPP_MODE_VERBOSE_BIT 5
`define CPP_PPI_MAX_BIT 8
`define CPP_KBPS_MAX_BIT 31
`define CPP_HOLD_INDEF_BIT 31
`define CPP_CMD_RELEASE_BIT 0
`define CPP_CMD_ALLOC_BIT 1
`define CPP_CMD_FREE_BIT 2
// ==========================================================
// reset values and limits
`define CPP_NUM_POL 16
`define CPP_MODE_RST 6'h10
`define CPP_PPI_RST 9'h100
`define CPP_WITHIN_RST 15'h0001
`define CPP_INIT_RST 8'h01
`define CPP_DETECT_RST 17'h0001e
`define CPP_WITHIN_MIN 15'h0001
`define CPP_DETECT_MAX 17'h1f400
`define CPP_HOLD_MAX 14'h2760
`define CPP_KBPS_MAX 25'h1312d00
`define CPP_MBS_MAX 23'h400000
`define CPP_POOL_MIN 16'h03e8
`define CPP_POOL_MAX 16'h8000
// ==========================================================
// timing
`define CPP_CLK_HZ 50000000
`define CPP_SEC_S 1
`define CPP_SEC_CYC (`CPP_CLK_HZ * `CPP_SEC_S)
`define CPP_DEF_MBS_MS 10
`endif

// >>> cpp_pkg.sv
// types of the control packet policer
package cpp_pkg;
   typedef enum logic [1:0] {
      CPP_ACT_NONE = 2'b00,
      CPP_ACT_DISCARD = 2'b01,
      CPP_ACT_LOWPRI = 2'b10
   } cpp_action_t;
   typedef enum logic [1:0] {
      CPP_ST_IDLE = 2'b00,
      CPP_ST_HOLD = 2'b01,
      CPP_ST_DETECT = 2'b10
   } cpp_state_t;
endpackage : cpp_pkg

// >>> cpp_policer.sv
// per-object control packet policer array with register port and pool counters
//
// Overview of operation
// (R1) sixteen independent policer instances, selected by index
// (R2) each limits by packets per interval or kilobits per second plus burst
// (R3) unreachable settings are clamped to nearest supported value, readable back; interval, ppi and startup burst above field width are truncated instead
// (R4) reset gives packet mode, unlimited count, one second interval
// (R5) ppi 0..255 or unlimited; zero fails all, unlimited passes all
// (R6) measurement interval 1..32767 seconds
// (R7) startup burst 1..255 added whenever bucket is full-refilled or drained
// (R8) bit rate 1..20000000 kbps or unlimited, unlimited always conforms
// (R9) burst 0..4194304 bytes or kilobytes; zero fails all at a limited rate
// (R10) unset burst defaults to 10 ms worth of data at the rate
// (R11) exceed state lasts until detect time conforming, 1..128000 s, default 30
// (R12) detect countdown starts only after hold-down ends
// (R13) overrate in countdown re-enters hold-down, countdown restarts full
// (R14) exceed reported through hold-down and countdown
// (R15) dynamic pool size 0 or 1000..32k, default 0
// (R16) pool size change clears high-water mark, timestamp, failures
// (R17) size below allocated frees all dynamic policers
// (R18) overrate action discard or low priority with hold-down, or none
// (R19) low priority packets marked for preferential discard under congestion
// (R20) during hold-down all packets marked or dropped, state still updates
// (R21) hold-down 1..10080 s clears after that time; zero means none
// (R22) indefinite hold-down lasts until operator release
// (R23) local monitors never apply hold-down
// (R24) exceed/conform events by default, hold events when verbose, can disable
// (R25) token bucket judges each packet in the arrival cycle
//
// Chosen here: the address map and the address-and-strobe port.
`timescale 1ns/1ps
`include "cpp_cfg.svh"
module cpp_policer
   import cpp_pkg::*;
(
   input wire logic clk_i,
   input wire logic rst_n_i,
   input wire logic ce_i,
   input wire logic [`CPP_ADDR_W-1:0] addr_i,
   input wire logic [31:0] wdata_i,
   input wire logic wr_i,
   input wire logic rd_i,
   output logic [31:0] rdata_o,
   input wire logic pkt_valid_i,
   input wire logic [3:0] pkt_pol_i,
   input wire logic [15:0] pkt_len_i,
   output logic pkt_valid_o,
   output logic pkt_drop_o,
   output logic pkt_lowpri_o,
   output logic evt_valid_o,
   output logic [3:0] evt_pol_o,
   output logic [1:0] evt_code_o
);
   localparam int NP = `CPP_NUM_POL;
   // ==========================================================
   // per-policer configuration
   logic [3:0] sel_q;
   logic [5:0] mode_q [NP];
   logic [8:0] ppi_q [NP];
   logic [14:0] within_q [NP];
   logic [7:0] init_q [NP];
   logic [24:0] kbps_q [NP];
   logic kbps_max_q [NP];
   logic [22:0] mbs_q [NP];
   logic [16:0] detect_q [NP];
   cpp_action_t act_q [NP];
   logic [13:0] hold_q [NP];
   logic indef_q [NP];
   // state
   cpp_state_t st_q [NP];
   logic [16:0] tmr_q [NP];
   logic [33:0] tok_q [NP];
   logic [14:0] win_q [NP];
   logic [15:0] pool_q, alloc_q, hwm_q, fail_q;
   logic [31:0] hwm_ts_q, secs_q;
   logic [25:0] sec_cnt_q;
   logic tick;
   // seconds tick shared by all timers
   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         sec_cnt_q <= 26'h0;
         secs_q <= 32'h0;
      end else if (ce_i) begin
         if (sec_cnt_q == 26'(`CPP_SEC_CYC - 1)) begin
            sec_cnt_q <= 26'h0;
            secs_q <= secs_q + 32'h1;
         end else begin
            sec_cnt_q <= sec_cnt_q + 26'h1;
         end
      end
   end
   assign tick = (sec_cnt_q == 26'(`CPP_SEC_CYC - 1));
   // ==========================================================
   // register writes, clamped to supported values
   wire wsel = ce_i && wr_i;
   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         sel_q <= 4'h0;
         for (int i = 0; i < NP; i++) begin
            mode_q[i] <= `CPP_MODE_RST; // (R4)
            ppi_q[i] <= `CPP_PPI_RST; // (R4)
            within_q[i] <= `CPP_WITHIN_RST; // (R4)
            init_q[i] <= `CPP_INIT_RST;
            kbps_q[i] <= 25'h0;
            kbps_max_q[i] <= 1'b1;
            mbs_q[i] <= 23'h0;
            detect_q[i] <= `CPP_DETECT_RST; // (R11)
            act_q[i] <= CPP_ACT_NONE; // (R18)
            hold_q[i] <= 14'h0;
            indef_q[i] <= 1'b0;
         end
      end else if (wsel) begin
         case (addr_i)
            `CPP_OFS_SEL: sel_q <= wdata_i[3:0]; // (R1)
            `CPP_OFS_MODE: mode_q[sel_q] <= wdata_i[5:0]; // (R2) (R24)
            `CPP_OFS_PPI: ppi_q[sel_q] <= wdata_i[8:0]; // (R5)
            `CPP_OFS_WITHIN: within_q[sel_q] <= (wdata_i[14:0] == 15'h0) ?
               `CPP_WITHIN_MIN : wdata_i[14:0]; // (R6) (R3)
            `CPP_OFS_INIT: init_q[sel_q] <= (wdata_i[7:0] == 8'h0) ?
               8'h01 : wdata_i[7:0]; // (R7) (R3)
            `CPP_OFS_KBPS: begin
               kbps_max_q[sel_q] <= wdata_i[`CPP_KBPS_MAX_BIT]; // (R8)
               kbps_q[sel_q] <= (wdata_i[30:0] > 31'(`CPP_KBPS_MAX)) ? `CPP_KBPS_MAX :
                  ((wdata_i[24:0] == 25'h0) ? 25'h1 : wdata_i[24:0]); // (R3)
            end
            `CPP_OFS_MBS: mbs_q[sel_q] <= (wdata_i[30:0] > 31'(`CPP_MBS_MAX)) ?
               `CPP_MBS_MAX : wdata_i[22:0]; // (R9) (R3)
            // range check first: a large value with zero low bits must clamp high, not to 1
            `CPP_OFS_DETECT: detect_q[sel_q] <= (wdata_i[30:0] > 31'(`CPP_DETECT_MAX)) ?
               `CPP_DETECT_MAX : ((wdata_i[16:0] == 17'h0) ? 17'h1 :
               wdata_i[16:0]); // (R11) (R3)
            `CPP_OFS_ACTION: act_q[sel_q] <= (wdata_i[1:0] == 2'b11) ? CPP_ACT_NONE :
               cpp_action_t'(wdata_i[1:0]); // (R18)
            `CPP_OFS_HOLD: begin
               indef_q[sel_q] <= wdata_i[`CPP_HOLD_INDEF_BIT]; // (R22)
               hold_q[sel_q] <= (wdata_i[30:0] > 31'(`CPP_HOLD_MAX)) ? `CPP_HOLD_MAX :
                  wdata_i[13:0]; // (R21) (R3)
            end
            default: ;
         endcase
      end
   end
   // ==========================================================
   // token bucket per policer, judged in the arrival cycle
   logic [33:0] cap [NP];
   logic [33:0] refill [NP];
   logic [NP-1:0] unlimited, conform_now;
   logic [33:0] need;
   always_comb begin
      need = 34'h0;
      for (int i = 0; i < NP; i++) begin
         if (mode_q[i][`CPP_MODE_KBPS_BIT]) begin
            unlimited[i] = kbps_max_q[i]; // (R8)
            // burst in bytes; default 10 ms of data is kbps*10/8 bytes
            if (mode_q[i][`CPP_MODE_MBS_SET_BIT])
               cap[i] = mode_q[i][`CPP_MODE_MBS_KB_BIT] ?
                  {1'b0, mbs_q[i], 10'h0} : {11'h0, mbs_q[i]}; // (R9)
            else
               cap[i] = 34'((kbps_q[i] * 34'(`CPP_DEF_MBS_MS)) >> 3); // (R10)
            refill[i] = 34'(kbps_q[i] * 34'd125); // bytes per second
         end else begin
            unlimited[i] = ppi_q[i][`CPP_PPI_MAX_BIT]; // (R5)
            cap[i] = 34'(ppi_q[i][7:0]) + 34'(init_q[i]); // (R7)
            refill[i] = 34'(ppi_q[i][7:0]);
         end
         need = mode_q[i][`CPP_MODE_KBPS_BIT] ? 34'(pkt_len_i) : 34'h1;
         // zero packet rate or zero burst fails every packet of a policer that is not unlimited, whatever the tokens
         conform_now[i] = unlimited[i] || (tok_q[i] >= need && need != 34'h0 &&
            cap[i] != 34'h0 && (mode_q[i][`CPP_MODE_KBPS_BIT] || ppi_q[i][7:0] != 8'h0)); // (R25) (R5) (R9)
      end
   end
   // a drained bucket refills the startup burst too
   logic [NP-1:0] fresh_q;
   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         for (int i = 0; i < NP; i++) begin
            tok_q[i] <= 34'h0;
            win_q[i] <= 15'h0;
            fresh_q[i] <= 1'b1;
         end
      end else if (ce_i) begin
         for (int i = 0; i < NP; i++) begin
            // reset or a rate write loads the bucket at once, not a second later
            fresh_q[i] <= wsel && sel_q == 4'(i) && addr_i >= `CPP_OFS_MODE &&
               addr_i <= `CPP_OFS_MBS; // (R7)
            if (fresh_q[i]) begin
               win_q[i] <= 15'h0;
               tok_q[i] <= cap[i]; // (R7)
            end else if (tick && (win_q[i] + 15'h1 >= within_q[i] ||
                  mode_q[i][`CPP_MODE_KBPS_BIT])) begin
               win_q[i] <= 15'h0; // (R6)
               tok_q[i] <= (tok_q[i] == 34'h0) ? cap[i] :
                  ((tok_q[i] + refill[i] > cap[i]) ? cap[i] : tok_q[i] + refill[i]); // (R7)
            end else begin
               if (tick)
                  win_q[i] <= win_q[i] + 15'h1;
               if (pkt_valid_i && pkt_pol_i == 4'(i) && conform_now[i] && !unlimited[i])
                  tok_q[i] <= tok_q[i] - (mode_q[i][`CPP_MODE_KBPS_BIT] ?
                     34'(pkt_len_i) : 34'h1); // (R25)
            end
         end
      end
   end
   // ==========================================================
   // exceed state machine: hold-down then detection countdown
   wire [3:0] p = pkt_pol_i;
   wire over = pkt_valid_i && !conform_now[p];
   wire rel = wsel && addr_i == `CPP_OFS_CMD && wdata_i[`CPP_CMD_RELEASE_BIT];
   logic ev_v;
   logic [3:0] ev_p;
   logic [1:0] ev_c;
   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         for (int i = 0; i < NP; i++) begin
            st_q[i] <= CPP_ST_IDLE;
            tmr_q[i] <= 17'h0;
         end
      end else if (ce_i) begin
         for (int i = 0; i < NP; i++) begin
            logic hd, ov;
            hd = !mode_q[i][`CPP_MODE_LOCMON_BIT] && act_q[i] != CPP_ACT_NONE &&
               (indef_q[i] || hold_q[i] != 14'h0); // (R23) (R21)
            ov = over && p == 4'(i);
            case (st_q[i])
               CPP_ST_IDLE: if (ov) begin
                  st_q[i] <= hd ? CPP_ST_HOLD : CPP_ST_DETECT;
                  tmr_q[i] <= hd ? 17'(hold_q[i]) : detect_q[i];
               end
               CPP_ST_HOLD: begin
                  if ((rel && sel_q == 4'(i)) ||
                        (!indef_q[i] && tick && tmr_q[i] <= 17'h1)) begin
                     st_q[i] <= CPP_ST_DETECT; // (R12) (R22)
                     tmr_q[i] <= detect_q[i];
                  end else if (tick && !indef_q[i]) begin
                     tmr_q[i] <= tmr_q[i] - 17'h1; // (R21)
                  end
               end
               CPP_ST_DETECT: begin
                  if (ov) begin
                     st_q[i] <= hd ? CPP_ST_HOLD : CPP_ST_DETECT; // (R13)
                     tmr_q[i] <= hd ? 17'(hold_q[i]) : detect_q[i]; // (R13)
                  end else if (tick && tmr_q[i] <= 17'h1) begin
                     st_q[i] <= CPP_ST_IDLE; // (R11)
                  end else if (tick) begin
                     tmr_q[i] <= tmr_q[i] - 17'h1;
                  end
               end
               default: st_q[i] <= CPP_ST_IDLE;
            endcase
         end
      end
   end
   // events when logging is enabled: exceed/conform, hold re-entry and hold end only in verbose
   always_comb begin
      ev_v = 1'b0;
      ev_p = 4'h0;
      ev_c = 2'b00;
      for (int i = 0; i < NP; i++) begin
         if (!ev_v && mode_q[i][`CPP_MODE_LOG_EN_BIT]) begin
            if (st_q[i] == CPP_ST_IDLE && over && p == 4'(i)) begin
               ev_v = 1'b1; ev_p = 4'(i); ev_c = 2'b00; // (R24)
            end else if (st_q[i] == CPP_ST_DETECT && tick && tmr_q[i] <= 17'h1 &&
                  !(over && p == 4'(i))) begin
               ev_v = 1'b1; ev_p = 4'(i); ev_c = 2'b01; // (R24)
            end else if (mode_q[i][`CPP_MODE_VERBOSE_BIT] && st_q[i] == CPP_ST_DETECT &&
                  over && p == 4'(i) && !mode_q[i][`CPP_MODE_LOCMON_BIT] &&
                  act_q[i] != CPP_ACT_NONE && (indef_q[i] || hold_q[i] != 14'h0)) begin
               ev_v = 1'b1; ev_p = 4'(i); ev_c = 2'b10; // (R24) (R13)
            end else if (mode_q[i][`CPP_MODE_VERBOSE_BIT] && st_q[i] == CPP_ST_HOLD &&
                  ((!indef_q[i] && tick && tmr_q[i] <= 17'h1) || (rel && sel_q == 4'(i)))) begin
               ev_v = 1'b1; ev_p = 4'(i); ev_c = 2'b11; // (R24)
            end
         end
      end
   end
   // packet verdict and event registers
   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         pkt_valid_o <= 1'b0;
         pkt_drop_o <= 1'b0;
         pkt_lowpri_o <= 1'b0;
         evt_valid_o <= 1'b0;
         evt_pol_o <= 4'h0;
         evt_code_o <= 2'b00;
      end else if (ce_i) begin
         logic all;
         all = st_q[p] == CPP_ST_HOLD; // (R20)
         pkt_valid_o <= pkt_valid_i;
         pkt_drop_o <= pkt_valid_i && act_q[p] == CPP_ACT_DISCARD &&
            (!conform_now[p] || all); // (R18) (R20)
         pkt_lowpri_o <= pkt_valid_i && act_q[p] == CPP_ACT_LOWPRI &&
            (!conform_now[p] || all); // (R19) (R20)
         evt_valid_o <= ev_v;
         evt_pol_o <= ev_p;
         evt_code_o <= ev_c;
      end
   end
   // ==========================================================
   // dynamic pool bookkeeping
   wire pool_wr = wsel && addr_i == `CPP_OFS_POOL;
   wire [15:0] pool_new = (wdata_i[15:0] == 16'h0 && wdata_i[31:16] == 16'h0) ? 16'h0 :
      ((wdata_i[31:0] < 32'(`CPP_POOL_MIN)) ? `CPP_POOL_MIN :
      ((wdata_i[31:0] > 32'(`CPP_POOL_MAX)) ? `CPP_POOL_MAX : wdata_i[15:0])); // (R15) (R3)
   wire do_alloc = wsel && addr_i == `CPP_OFS_CMD && wdata_i[`CPP_CMD_ALLOC_BIT];
   wire do_free = wsel && addr_i == `CPP_OFS_CMD && wdata_i[`CPP_CMD_FREE_BIT];
   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         pool_q <= 16'h0; // (R15)
         alloc_q <= 16'h0;
         hwm_q <= 16'h0;
         hwm_ts_q <= 32'h0;
         fail_q <= 16'h0;
      end else if (pool_wr) begin
         pool_q <= pool_new;
         hwm_q <= 16'h0; // (R16)
         hwm_ts_q <= 32'h0; // (R16)
         fail_q <= 16'h0; // (R16)
         if (pool_new < alloc_q)
            alloc_q <= 16'h0; // (R17)
      end else if (do_alloc) begin
         if (alloc_q < pool_q) begin
            alloc_q <= alloc_q + 16'h1;
            if (alloc_q + 16'h1 > hwm_q) begin
               hwm_q <= alloc_q + 16'h1;
               hwm_ts_q <= secs_q;
            end
         end else begin
            fail_q <= fail_q + 16'h1;
         end
      end else if (do_free && alloc_q != 16'h0) begin
         alloc_q <= alloc_q - 16'h1;
      end
   end
   // ==========================================================
   // register reads, one cycle after the strobe
   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         rdata_o <= 32'h0;
      end else if (ce_i) begin
         rdata_o <= 32'h0;
         if (rd_i) begin
            case (addr_i)
               `CPP_OFS_SEL: rdata_o <= {28'h0, sel_q};
               `CPP_OFS_MODE: rdata_o <= {26'h0, mode_q[sel_q]};
               `CPP_OFS_PPI: rdata_o <= {23'h0, ppi_q[sel_q]};
               `CPP_OFS_WITHIN: rdata_o <= {17'h0, within_q[sel_q]};
               `CPP_OFS_INIT: rdata_o <= {24'h0, init_q[sel_q]};
               `CPP_OFS_KBPS: rdata_o <= {kbps_max_q[sel_q], 6'h0, kbps_q[sel_q]};
               `CPP_OFS_MBS: rdata_o <= {9'h0, mbs_q[sel_q]};
               `CPP_OFS_DETECT: rdata_o <= {15'h0, detect_q[sel_q]};
               `CPP_OFS_ACTION: rdata_o <= {30'h0, act_q[sel_q]};
               `CPP_OFS_HOLD: rdata_o <= {indef_q[sel_q], 17'h0, hold_q[sel_q]};
               `CPP_OFS_STATUS: rdata_o <= {12'h0, tmr_q[sel_q],
                  (st_q[sel_q] != CPP_ST_IDLE), st_q[sel_q]}; // (R14)
               `CPP_OFS_POOL: rdata_o <= {alloc_q, pool_q};
               `CPP_OFS_POOLST: rdata_o <= {hwm_q, fail_q};
               `CPP_OFS_CMD: rdata_o <= hwm_ts_q;
               default: rdata_o <= 32'h0;
            endcase
         end
      end
   end
   // ==========================================================
   // checks
   hold_marks_a: assert property (@(posedge clk_i) disable iff (!rst_n_i) // (R20)
      ce_i && pkt_valid_i && st_q[pkt_pol_i] == CPP_ST_HOLD &&
      act_q[pkt_pol_i] == CPP_ACT_DISCARD |=> pkt_drop_o)
      else $error("hold-down did not drop packet");
   unlim_pass_a: assert property (@(posedge clk_i) disable iff (!rst_n_i) // (R5)
      ce_i && pkt_valid_i && unlimited[pkt_pol_i] && st_q[pkt_pol_i] != CPP_ST_HOLD
      |=> !pkt_drop_o && !pkt_lowpri_o)
      else $error("unlimited policer refused a packet");
   none_nodrop_a: assert property (@(posedge clk_i) disable iff (!rst_n_i) // (R18)
      ce_i && pkt_valid_i && act_q[pkt_pol_i] == CPP_ACT_NONE |=> !pkt_drop_o && !pkt_lowpri_o)
      else $error("action none altered packet");
   pool_clear_a: assert property (@(posedge clk_i) disable iff (!rst_n_i) // (R16)
      pool_wr |=> hwm_q == 16'h0 && fail_q == 16'h0)
      else $error("pool change kept statistics");
   pool_shrink_a: assert property (@(posedge clk_i) disable iff (!rst_n_i) // (R17)
      pool_wr && pool_new < alloc_q |=> alloc_q == 16'h0)
      else $error("pool shrink did not free policers");
   locmon_hold_a: assert property (@(posedge clk_i) disable iff (!rst_n_i) // (R23)
      ce_i && over && mode_q[p][`CPP_MODE_LOCMON_BIT] && st_q[p] == CPP_ST_IDLE
      |=> st_q[$past(p)] == CPP_ST_DETECT)
      else $error("local monitor entered hold-down");
   exceed_enter_a: assert property (@(posedge clk_i) disable iff (!rst_n_i) // (R14)
      ce_i && over && st_q[p] == CPP_ST_IDLE |=> st_q[$past(p)] != CPP_ST_IDLE)
      else $error("overrate did not enter exceed");
   rd_latency_a: assert property (@(posedge clk_i) disable iff (!rst_n_i) // read data is zero outside the cycle after a strobe
      ce_i && !rd_i |=> rdata_o == 32'h0)
      else $error("read data outside its cycle");
   hold_cov: cover property (@(posedge clk_i) st_q[0] == CPP_ST_HOLD);
   recover_cov: cover property (@(posedge clk_i) evt_valid_o && evt_code_o == 2'b01);
   fail_cov: cover property (@(posedge clk_i) do_alloc && alloc_q >= pool_q);
endmodule : cpp_policer

// >>> cpp_pkt_src.sv
// packet extraction pipeline model feeding the policer's packet port
`timescale 1ns/1ps
module cpp_pkt_src (
   input wire logic clk_i,
   input wire logic rst_n_i,
   input wire logic en_i,
   input wire logic [3:0] pol_i,
   input wire logic [15:0] len_i,
   output logic pkt_valid_o,
   output logic [3:0] pkt_pol_o,
   output logic [15:0] pkt_len_o
);
   // ==========================================================
   // one packet per enabled cycle; idle fields toggle so stale values never look valid
   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         pkt_valid_o <= 1'b0;
         pkt_pol_o <= 4'h0;
         pkt_len_o <= 16'h0000;
      end else if (en_i) begin
         pkt_valid_o <= 1'b1;
         pkt_pol_o <= pol_i;
         pkt_len_o <= len_i;
      end else begin
         pkt_valid_o <= 1'b0;
         pkt_pol_o <= ~pkt_pol_o;
         pkt_len_o <= ~pkt_len_o;
      end
   end
endmodule : cpp_pkt_src

// >>> control_plane_packet_policer_bench.sv
// self-checking bench for the control packet policer
`timescale 1ns/1ps
`include "cpp_cfg.svh"
module control_plane_packet_policer_bench;
   import cpp_pkg::*;
   logic clk_i = 1'b0, rst_n_i = 1'b0, ce_i = 1'b1, wr_i = 1'b0, rd_i = 1'b0, en = 1'b0;
   logic [3:0] addr_i = 4'h0, pol = 4'h0;
   logic [31:0] wdata_i = 32'h0, d;
   logic [15:0] len = 16'h0040;
   logic [31:0] rdata_o;
   logic pkt_valid_i, pkt_valid_o, pkt_drop_o, pkt_lowpri_o, evt_valid_o;
   logic [3:0] pkt_pol_i, evt_pol_o, ev_pol;
   logic [15:0] pkt_len_i;
   logic [1:0] evt_code_o, ev_code;
   int miscompares = 0, n_tests = 0, cycles = 0, ev_n = 0, ev0, seed = 89;
   logic [3:0] rst_a [9] = '{4'h1, 4'h2, 4'h3, 4'h4, 4'h7, 4'h8, 4'h9, 4'hb, 4'he};
   logic [31:0] rst_v [9] = '{32'h10, 32'h100, 32'h1, 32'h1, 32'h1e, 32'h0, 32'h0, 32'h0, 32'h0};

   always #10 clk_i = ~clk_i;

   cpp_pkt_src u_src (.clk_i(clk_i), .rst_n_i(rst_n_i), .en_i(en), .pol_i(pol), .len_i(len),
      .pkt_valid_o(pkt_valid_i), .pkt_pol_o(pkt_pol_i), .pkt_len_o(pkt_len_i));
   cpp_policer u_dut (.clk_i(clk_i), .rst_n_i(rst_n_i), .ce_i(ce_i), .addr_i(addr_i),
      .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
      .pkt_valid_i(pkt_valid_i), .pkt_pol_i(pkt_pol_i), .pkt_len_i(pkt_len_i),
      .pkt_valid_o(pkt_valid_o), .pkt_drop_o(pkt_drop_o), .pkt_lowpri_o(pkt_lowpri_o),
      .evt_valid_o(evt_valid_o), .evt_pol_o(evt_pol_o), .evt_code_o(evt_code_o));

   // ==========================================================
   // event recorder and hang guard
   always @(posedge clk_i) begin
      cycles <= cycles + 1;
      if (evt_valid_o === 1'b1) begin
         ev_n <= ev_n + 1;
         ev_pol <= evt_pol_o;
         ev_code <= evt_code_o;
      end
      if (cycles == 20000) begin
         miscompares = miscompares + 1;
         summarize();
      end
   end

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp) begin
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
         miscompares++;
      end
   endtask : chk

   task automatic wr(input logic [3:0] a, input logic [31:0] v);
      @(posedge clk_i);
      addr_i <= a;
      wdata_i <= v;
      wr_i <= 1'b1;
      @(posedge clk_i);
      wr_i <= 1'b0;
   endtask : wr

   // read data stands only in the cycle after the strobe
   task automatic rd(input logic [3:0] a, output logic [31:0] v);
      @(posedge clk_i);
      addr_i <= a;
      rd_i <= 1'b1;
      @(posedge clk_i);
      rd_i <= 1'b0;
      @(negedge clk_i);
      v = rdata_o;
   endtask : rd

   // expected verdict {valid, drop, lowpri} for a nonconforming or conforming packet
   function automatic logic [2:0] exp_verdict(input logic [1:0] act, input logic bad);
      return {1'b1, bad && act == 2'h1, bad && act == 2'h2};
   endfunction : exp_verdict

   // one packet through the source model, verdict sampled once it has landed
   task automatic pkt(input logic [3:0] p, input logic [2:0] exp);
      @(posedge clk_i);
      en <= 1'b1;
      pol <= p;
      len <= 16'h0040 + 16'($unsigned($random(seed)) % 1400);
      @(posedge clk_i);
      en <= 1'b0;
      @(posedge clk_i);
      @(negedge clk_i);
      chk({29'h0, pkt_valid_o, pkt_drop_o, pkt_lowpri_o}, {29'h0, exp});
   endtask : pkt

   task automatic summarize();
      $display("tests=%0d mismatches=%0d", n_tests, miscompares);
      if (miscompares == 0 && n_tests > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask : summarize

   // ==========================================================
   // main sequence
   initial begin
      repeat (2) @(posedge clk_i);
      rst_n_i <= 1'b1;
      wr(4'h0, 32'h0);
      for (int i = 0; i < 9; i++) begin
         rd(rst_a[i], d);
         chk(d, rst_v[i]);
      end
      rd(4'h5, d);
      chk({31'h0, d[31]}, 32'h1);
      $display("reset values done");
      // out-of-range settings clamp to the nearest supported value; an unmapped offset reads zero
      wr(4'h3, 32'h0);
      rd(4'h3, d);
      chk(d, 32'h1);
      wr(4'h7, 32'h20000);
      rd(4'h7, d);
      chk(d, 32'h1f400);
      wr(4'h9, 32'h4e20);
      rd(4'h9, d);
      chk(d, 32'h2760);
      wr(4'hf, 32'hffff);
      rd(4'hf, d);
      chk(d, 32'h0);
      // a low clock enable freezes the register file
      ce_i <= 1'b0;
      wr(4'h3, 32'h7);
      ce_i <= 1'b1;
      rd(4'h3, d);
      chk(d, 32'h1);
      $display("clamp done");
      // zero packets per interval: every packet nonconforming, all actions
      wr(4'h0, 32'h5);
      wr(4'h2, 32'h0);
      ev0 = ev_n;
      for (int a = 1; a >= 0; a = (a == 1) ? 2 : ((a == 2) ? 0 : -1)) begin
         wr(4'h8, a);
         repeat (3) pkt(4'h5, exp_verdict(a[1:0], 1'b1));
      end
      repeat (8) @(posedge clk_i);
      chk(32'(ev_n > ev0), 32'h1);
      chk({28'h0, ev_pol}, 32'h5);
      chk({30'h0, ev_code}, 32'h0);
      // same on a silent local monitor with a hold-down set: no event, no hold
      wr(4'h0, 32'h6);
      wr(4'h1, 32'h8);
      wr(4'h9, 32'h5);
      wr(4'h2, 32'h0);
      wr(4'h8, 32'h1);
      ev0 = ev_n;
      repeat (3) pkt(4'h6, exp_verdict(2'h1, 1'b1));
      repeat (8) @(posedge clk_i);
      chk(32'(ev_n), 32'(ev0));
      rd(4'ha, d);
      chk(d, {12'h0, 17'h1e, 3'b110});
      $display("packet mode done");
      // bit-rate mode: zero burst fails all, unlimited rate passes all
      wr(4'h0, 32'h7);
      wr(4'h1, 32'h15);
      wr(4'h5, 32'd1000);
      wr(4'h6, 32'h0);
      wr(4'h8, 32'h1);
      repeat (3) pkt(4'h7, exp_verdict(2'h1, 1'b1));
      wr(4'h5, 32'h80000000);
      repeat (3) pkt(4'h7, exp_verdict(2'h1, 1'b0));
      $display("rate mode done");
      // hold-down on policer 4: conforming packets still dropped until release
      wr(4'h0, 32'h4);
      wr(4'h1, 32'h30);
      wr(4'h2, 32'h0);
      wr(4'h8, 32'h1);
      wr(4'h9, 32'h2);
      pkt(4'h4, exp_verdict(2'h1, 1'b1));
      wr(4'h2, 32'h100);
      pkt(4'h4, exp_verdict(2'h1, 1'b1));
      rd(4'ha, d);
      chk(d, {12'h0, 17'h2, 3'b101});
      wr(4'hd, 32'h1);
      repeat (2) @(posedge clk_i);
      chk({30'h0, ev_code}, 32'h3);
      pkt(4'h4, exp_verdict(2'h1, 1'b0));
      rd(4'ha, d);
      chk(d, {12'h0, 17'h1e, 3'b110});
      // a fresh overrate in the countdown re-enters hold-down
      wr(4'h2, 32'h0);
      pkt(4'h4, exp_verdict(2'h1, 1'b1));
      repeat (2) @(posedge clk_i);
      chk({30'h0, ev_code}, 32'h2);
      rd(4'ha, d);
      chk(d, {12'h0, 17'h2, 3'b101});
      $display("hold-down done");
      // untouched policers stay unlimited under random traffic
      for (int i = 0; i < 40; i++)
         pkt(4'h8 + 4'($unsigned($random(seed)) % 8), exp_verdict(2'h0, 1'b0));
      $display("random traffic done");
      // dynamic pool: size clamps, size change clears statistics
      wr(4'hb, 32'd500);
      rd(4'hb, d);
      chk({16'h0, d[15:0]}, 32'd1000);
      repeat (3) wr(4'hd, 32'h2);
      rd(4'hc, d);
      chk(d, 32'h00030000);
      wr(4'hb, 32'd1200);
      rd(4'hc, d);
      chk(d, 32'h0);
      rd(4'hd, d);
      chk(d, 32'h0);
      wr(4'hb, 32'h0);
      rd(4'hb, d);
      chk(d, 32'h0);
      $display("pool done");
      summarize();
   end
endmodule : control_plane_packet_policer_bench
